// ---- cptlv_top.sv ----
// Builder of the proprietary-information objects streamed by the card.
// Assumes AHB-Lite master on hclk; byte stream sink on the same clock.
//
// The AHB-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
module cptlv_top #(
  parameter int MINCK_N = 2               // Minimum clock objects held
) (
  input  wire logic        hclk,          // Clock, 200 MHz
  input  wire logic        hresetn,       // Async reset, active low
  input  wire logic        hsel,          // Slave select
  input  wire logic [31:0] haddr,         // Address
  input  wire logic [1:0]  htrans,        // Transfer type
  input  wire logic        hwrite,        // Write strobe
  input  wire logic [2:0]  hsize,         // Transfer size
  input  wire logic [31:0] hwdata,        // Write data
  input  wire logic        hready,        // Bus ready in
  output logic      [31:0] hrdata,        // Read data
  output logic             hreadyout,     // Slave ready
  output logic             hresp,         // Response, always OKAY
  output logic      [7:0]  tx_byte,       // Object stream byte
  output logic             tx_valid,      // Byte valid
  input  wire logic        tx_ready       // Sink accepts byte
);

  ////////////////////////////////////////////////////////////////////////
  // Byte helpers
  // Clean characteristics byte: reserved bits forced low
  function automatic logic [7:0] char_clean(input logic [7:0] v);
    char_clean = {1'b0, v[6:2], 1'b0, v[0]} & 8'h7D;
  endfunction

  // Current byte: reserved top bits low, 00 raised to 01, over-limit clamped to max
  function automatic logic [7:0] cur_clean(input logic [7:0] v);
    logic [5:0] c;
    c = v[5:0];
    if (c == 6'h00) c = 6'h01;
    else if (c > cptlv_pkg::CUR_MAX) c = cptlv_pkg::CUR_MAX;
    cur_clean = {2'b00, c};
  endfunction

  // Frequency byte: below 1 MHz is meaningless, sent as no indication
  function automatic logic [7:0] freq_clean(input logic [7:0] v);
    freq_clean = (v < 8'h0A) ? cptlv_pkg::FREQ_NONE : v;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0]  char_r,  char_nxt;         // Characteristics byte
  logic [23:0] pwr_r,   pwr_nxt;          // Class, current, ref freq
  logic [7:0]  minck_r [MINCK_N];         // Minimum clock values
  logic [7:0]  minck_nxt [MINCK_N];       // Next minimum clock values
  logic [31:0] size_r,  size_nxt;         // [31:16] avail, [15:0] max
  logic [15:0] rsv_r,   rsv_nxt;          // Reserved size
  logic [15:0] misc_r,  misc_nxt;         // [15:8] sys cmds, [7:0] fdet
  logic [7:0]  ctrl_r,  ctrl_nxt;         // Object enables
  logic        go_r,    go_nxt;           // Start pulse
  logic        wr_r,    wr_nxt;           // Pending write data phase
  logic [7:0]  wa_r,    wa_nxt;           // Latched write address
  logic [15:0] avail_eff;                 // Clamped available count

  // ctrl bits: 0 power,1 minclk,2 avail,3 fdet,4 rsv,5 max,6 sysc
  // Available count limited by maximum size when limit enabled
  assign avail_eff = (ctrl_r[5] && size_r[31:16] > size_r[15:0]) ?
                     size_r[15:0] : size_r[31:16];

  // Bus write decode and register next state
  always_comb begin
    char_nxt  = char_r;
    pwr_nxt   = pwr_r;
    size_nxt  = size_r;
    rsv_nxt   = rsv_r;
    misc_nxt  = misc_r;
    ctrl_nxt  = ctrl_r;
    go_nxt    = 1'b0;
    for (int i = 0; i < MINCK_N; i++) begin
      minck_nxt[i] = minck_r[i];
    end
    wr_nxt = hsel && hready && htrans[1] && hwrite;
    wa_nxt = (hsel && hready && htrans[1]) ? haddr[7:0] : wa_r;
    if (wr_r) begin
      case (wa_r)
        cptlv_pkg::OFS_CTRL: begin
          ctrl_nxt = hwdata[7:0];
          go_nxt   = hwdata[31];
        end
        cptlv_pkg::OFS_CHAR:  char_nxt = char_clean(hwdata[7:0]);
        cptlv_pkg::OFS_POWER: begin
          pwr_nxt = {hwdata[23:16], cur_clean(hwdata[15:8]),
                     freq_clean(hwdata[7:0])};
        end
        cptlv_pkg::OFS_MINCK: begin
          for (int i = 0; i < MINCK_N; i++) begin
            minck_nxt[i] = hwdata[8*i +: 8];
          end
        end
        cptlv_pkg::OFS_SIZE:  size_nxt = hwdata;
        cptlv_pkg::OFS_RSV:   rsv_nxt  = hwdata[15:0];
        cptlv_pkg::OFS_MISC:  misc_nxt = {hwdata[15:8], 7'h00, hwdata[0]};
        default: ;                                      // Unmapped ignored
      endcase
    end
  end

  // Register storage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      char_r <= 8'h00;
      pwr_r  <= {16'h0001, cptlv_pkg::RST_FREQ};
      for (int i = 0; i < MINCK_N; i++) begin
        minck_r[i] <= cptlv_pkg::RST_FREQ;
      end
      size_r <= cptlv_pkg::RST_ZERO;
      rsv_r  <= 16'h0000;
      misc_r <= 16'h0000;
      ctrl_r <= 8'h00;
      go_r   <= 1'b0;
      wr_r   <= 1'b0;
      wa_r   <= 8'h00;
    end else begin
      char_r <= char_nxt;
      pwr_r  <= pwr_nxt;
      for (int i = 0; i < MINCK_N; i++) begin
        minck_r[i] <= minck_nxt[i];
      end
      size_r <= size_nxt;
      rsv_r  <= rsv_nxt;
      misc_r <= misc_nxt;
      ctrl_r <= ctrl_nxt;
      go_r   <= go_nxt;
      wr_r   <= wr_nxt;
      wa_r   <= wa_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Object sequencer
  cptlv_pkg::cptlv_state_type st_r, st_nxt; // Current object
  logic [2:0]  idx_r, idx_nxt;             // Byte index in object
  logic [7:0]  obj_r, obj_nxt;             // Minimum clock object index
  logic [7:0]  byte_c;                     // Byte of current object
  logic [2:0]  last_c;                     // Last index of object
  logic [7:0]  txb_r, txb_nxt;             // Registered output byte
  logic        txv_r, txv_nxt;             // Registered valid
  logic        busy;                       // Sequence running

  assign busy = (st_r != cptlv_pkg::S_IDLE);

  // Next enabled object after the given one; a loop, not recursion
  function automatic cptlv_pkg::cptlv_state_type next_obj(
    input cptlv_pkg::cptlv_state_type s, input logic [7:0] en);
    logic found;                           // First enabled one seen
    found    = 1'b0;
    next_obj = cptlv_pkg::S_IDLE;
    // Object codes 2..8 follow the characteristics; enable bit is code-2
    for (int n = 2; n <= 8; n++) begin
      if (!found && n > int'(s) && en[n-2]) begin
        next_obj = cptlv_pkg::cptlv_state_type'(4'(n));
        found    = 1'b1;
      end
    end
    if (s == cptlv_pkg::S_IDLE) next_obj = cptlv_pkg::S_CHAR;
  endfunction

  // Byte selection for each object, tag and length first
  always_comb begin
    byte_c = 8'h00;
    last_c = 3'd2;
    case (st_r)
      cptlv_pkg::S_CHAR: begin
        byte_c = (idx_r == 3'd0) ? cptlv_pkg::TAG_CHAR :
                 (idx_r == 3'd1) ? cptlv_pkg::LEN_ONE : char_r;
      end
      cptlv_pkg::S_POWER: begin
        last_c = 3'd4;
        case (idx_r)
          3'd0:    byte_c = cptlv_pkg::TAG_POWER;
          3'd1:    byte_c = cptlv_pkg::LEN_THREE;
          3'd2:    byte_c = pwr_r[23:16];
          3'd3:    byte_c = pwr_r[15:8];
          default: byte_c = pwr_r[7:0];
        endcase
      end
      cptlv_pkg::S_MINCK: begin
        byte_c = (idx_r == 3'd0) ? cptlv_pkg::TAG_MINCK :
                 (idx_r == 3'd1) ? cptlv_pkg::LEN_ONE :
                 minck_r[obj_r[$clog2(MINCK_N)-1:0]];
      end
      cptlv_pkg::S_AVAIL: begin
        last_c = 3'd3;
        byte_c = (idx_r == 3'd0) ? cptlv_pkg::TAG_AVAIL :
                 (idx_r == 3'd1) ? cptlv_pkg::LEN_SIZE :
                 (idx_r == 3'd2) ? avail_eff[15:8] : avail_eff[7:0];
      end
      cptlv_pkg::S_FDET: begin
        byte_c = (idx_r == 3'd0) ? cptlv_pkg::TAG_FDET :
                 (idx_r == 3'd1) ? cptlv_pkg::LEN_ONE :
                 {7'h00, misc_r[0]};
      end
      cptlv_pkg::S_RSV: begin
        last_c = 3'd3;
        byte_c = (idx_r == 3'd0) ? cptlv_pkg::TAG_RSV :
                 (idx_r == 3'd1) ? cptlv_pkg::LEN_SIZE :
                 (idx_r == 3'd2) ? rsv_r[15:8] : rsv_r[7:0];
      end
      cptlv_pkg::S_MAXSZ: begin
        last_c = 3'd3;
        byte_c = (idx_r == 3'd0) ? cptlv_pkg::TAG_MAXSZ :
                 (idx_r == 3'd1) ? cptlv_pkg::LEN_SIZE :
                 (idx_r == 3'd2) ? size_r[15:8] : size_r[7:0];
      end
      cptlv_pkg::S_SYSC: begin
        byte_c = (idx_r == 3'd0) ? cptlv_pkg::TAG_SYSC :
                 (idx_r == 3'd1) ? cptlv_pkg::LEN_ONE : misc_r[15:8];
      end
      default: byte_c = 8'h00;                                    // Idle
    endcase
  end

  // Sequencer next state: one byte per accepted handshake
  always_comb begin
    st_nxt  = st_r;
    idx_nxt = idx_r;
    obj_nxt = obj_r;
    txb_nxt = txb_r;
    txv_nxt = txv_r;
    if (txv_r && tx_ready) begin
      txv_nxt = 1'b0;                      // Byte taken
    end
    if (!busy) begin
      if (go_r) begin
        st_nxt  = cptlv_pkg::S_CHAR;
        idx_nxt = 3'd0;
        obj_nxt = 8'h00;
      end
    end else if (!txv_r || tx_ready) begin
      txb_nxt = byte_c;
      txv_nxt = 1'b1;
      if (idx_r == last_c) begin
        idx_nxt = 3'd0;
        if (st_r == cptlv_pkg::S_MINCK &&
            obj_r < 8'(MINCK_N - 1)) begin
          obj_nxt = obj_r + 8'h01;
        end else begin
          obj_nxt = 8'h00;
          st_nxt  = next_obj(st_r, ctrl_r);
        end
      end else begin
        idx_nxt = idx_r + 3'd1;
      end
    end
  end

  // Sequencer registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r  <= cptlv_pkg::S_IDLE;
      idx_r <= 3'd0;
      obj_r <= 8'h00;
      txb_r <= 8'h00;
      txv_r <= 1'b0;
    end else begin
      st_r  <= st_nxt;
      idx_r <= idx_nxt;
      obj_r <= obj_nxt;
      txb_r <= txb_nxt;
      txv_r <= txv_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path: registered read data, zero wait states
  logic [31:0] rd_r, rd_nxt;               // Read data register

  always_comb begin
    rd_nxt = rd_r;
    if (hsel && hready && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        cptlv_pkg::OFS_CTRL:  rd_nxt = {24'h000000, ctrl_r};
        cptlv_pkg::OFS_CHAR:  rd_nxt = {24'h000000, char_r};
        cptlv_pkg::OFS_POWER: rd_nxt = {8'h00, pwr_r};
        cptlv_pkg::OFS_MINCK: begin
          rd_nxt = 32'h0000_0000;
          for (int i = 0; i < MINCK_N && i < 4; i++) begin
            rd_nxt[8*i +: 8] = minck_r[i];
          end
        end
        cptlv_pkg::OFS_SIZE:  rd_nxt = size_r;
        cptlv_pkg::OFS_RSV:   rd_nxt = {16'h0000, rsv_r};
        cptlv_pkg::OFS_STAT:  rd_nxt = {16'h0000, avail_eff[7:0],
                                        3'b000, busy, st_r};
        cptlv_pkg::OFS_MISC:  rd_nxt = {16'h0000, misc_r};
        default:              rd_nxt = 32'h0000_0000;   // Unmapped reads 0
      endcase
    end
  end

  // Read data register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_r <= cptlv_pkg::RST_ZERO;
    end else begin
      rd_r <= rd_nxt;
    end
  end

  assign hrdata    = rd_r;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign tx_byte   = txb_r;
  assign tx_valid  = txv_r;

endmodule // cptlv_top
`default_nettype wire

// ---- cptlv_pkg.sv ----
// Package for the proprietary-information object builder.
// Assumes a single 200 MHz clock domain and AHB-Lite register access.
`default_nettype none
package cptlv_pkg;
  // Tags and fixed lengths of the built objects
  localparam logic [7:0] TAG_CHAR  = 8'h80;
  localparam logic [7:0] TAG_POWER = 8'h81;
  localparam logic [7:0] TAG_MINCK = 8'h82;
  localparam logic [7:0] TAG_AVAIL = 8'h83;
  localparam logic [7:0] TAG_FDET  = 8'h84;
  localparam logic [7:0] TAG_RSV   = 8'h85;
  localparam logic [7:0] TAG_MAXSZ = 8'h86;
  localparam logic [7:0] TAG_SYSC  = 8'h87;
  localparam logic [7:0] LEN_ONE   = 8'h01;
  localparam logic [7:0] LEN_THREE = 8'h03;
  localparam logic [7:0] LEN_SIZE  = 8'h02;
  // Value coding limits
  localparam logic [5:0] CUR_MAX   = 6'h3C;
  localparam logic [7:0] FREQ_NONE = 8'hFF;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_CHAR  = 8'h04;
  localparam logic [7:0] OFS_POWER = 8'h08;
  localparam logic [7:0] OFS_MINCK = 8'h0C;
  localparam logic [7:0] OFS_SIZE  = 8'h10;
  localparam logic [7:0] OFS_RSV   = 8'h14;
  localparam logic [7:0] OFS_STAT  = 8'h18;
  localparam logic [7:0] OFS_MISC  = 8'h1C;
  // Reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [7:0]  RST_FREQ = 8'hFF;
  // Object sequencer states
  typedef enum logic [3:0] {
    S_IDLE  = 4'b0000,
    S_CHAR  = 4'b0001,
    S_POWER = 4'b0010,
    S_MINCK = 4'b0011,
    S_AVAIL = 4'b0100,
    S_FDET  = 4'b0101,
    S_RSV   = 4'b0110,
    S_MAXSZ = 4'b0111,
    S_SYSC  = 4'b1000
  } cptlv_state_type;
endpackage
`default_nettype wire

// ---- cptlv_chk.sv ----
// Checker of the object stream and bus response of the builder.
// Assumes it is bound to cptlv_top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module cptlv_chk (
  input wire logic       hclk,      // Clock
  input wire logic       hresetn,   // Reset, active low
  input wire logic       hreadyout, // Slave ready
  input wire logic       hresp,     // Response
  input wire logic [7:0] tx_byte,   // Stream byte
  input wire logic       tx_valid,  // Byte valid
  input wire logic       tx_ready   // Sink ready
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [1:0] st_r, st_nxt;   // 0 tag, 1 length, 2 value
  logic [7:0] tag_r, tag_nxt; // Tag of the object in flight
  logic [7:0] rem_r, rem_nxt; // Value bytes still to come
  wire        acc = tx_valid && tx_ready; // Byte accepted
  ////////////////////////////////////////
  // Tiny parser that tracks object fields
  always_comb begin
    st_nxt = st_r;
    tag_nxt = tag_r;
    rem_nxt = rem_r;
    if (!tx_valid) begin // Frame over
      st_nxt = 2'd0;
    end else if (acc) begin
      case (st_r)
        2'd0: begin tag_nxt = tx_byte; st_nxt = 2'd1; end
        2'd1: begin
          rem_nxt = tx_byte;
          st_nxt = (tx_byte == 8'h00) ? 2'd0 : 2'd2;
        end
        default: begin
          rem_nxt = rem_r - 8'h01;
          if (rem_r == 8'h01) st_nxt = 2'd0;
        end
      endcase
    end
  end
  // Registers of the parser
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= 2'd0;
      tag_r <= 8'h00;
      rem_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      tag_r <= tag_nxt;
      rem_r <= rem_nxt;
    end
  end
  ////////////////////////////////////////
  property p_first_tag; $rose(tx_valid) |-> tx_byte == 8'h80; endproperty
  a_first_tag: assert property (p_first_tag) else $error("bad lead tag");
  property p_len_one;
    tx_valid && st_r == 2'd1 && tag_r inside {8'h80, 8'h82, 8'h84, 8'h87}
      |-> tx_byte == 8'h01;
  endproperty
  a_len_one: assert property (p_len_one) else $error("bad length");
  property p_len_pow;
    tx_valid && st_r == 2'd1 && tag_r == 8'h81 |-> tx_byte == 8'h03;
  endproperty
  a_len_pow: assert property (p_len_pow) else $error("bad power length");
  property p_len_size;
    tx_valid && st_r == 2'd1 && tag_r inside {8'h83, 8'h85, 8'h86}
      |-> tx_byte >= 8'h02;
  endproperty
  a_len_size: assert property (p_len_size) else $error("size too short");
  property p_char_rsv;
    tx_valid && st_r == 2'd2 && tag_r == 8'h80
      |-> tx_byte[7] == 1'b0 && tx_byte[1] == 1'b0;
  endproperty
  a_char_rsv: assert property (p_char_rsv) else $error("reserved bit set");
  property p_current;
    tx_valid && st_r == 2'd2 && tag_r == 8'h81 && rem_r == 8'h02
      |-> tx_byte inside {[8'h01:8'h3C]};
  endproperty
  a_current: assert property (p_current) else $error("bad current");
  property p_freq;
    tx_valid && st_r == 2'd2 && tag_r == 8'h81 && rem_r == 8'h01
      |-> tx_byte >= 8'h0A;
  endproperty
  a_freq: assert property (p_freq) else $error("bad frequency");
  property p_fdet;
    tx_valid && st_r == 2'd2 && tag_r == 8'h84 |-> tx_byte[7:1] == 7'h00;
  endproperty
  a_fdet: assert property (p_fdet) else $error("bad file details");
  property p_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte);
  endproperty
  a_hold: assert property (p_hold) else $error("byte dropped");
  property p_bus_okay;
    hreadyout && !hresp;
  endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus not okay");
endmodule // cptlv_chk
bind cptlv_top cptlv_chk u_chk (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready)
);
`default_nettype wire

// ---- cptlv_sink.sv ----
// Terminal side model that takes the object stream byte by byte.
// Assumes the stream clock is hclk; stall slows acceptance to 1 in 4.
`timescale 1ns/100ps
`default_nettype none
module cptlv_sink #(
  parameter logic [7:0] USE_CLASS = 8'h01 // Supply class in use
) (
  input  wire logic       hclk,     // Clock
  input  wire logic       hresetn,  // Reset, active low
  input  wire logic [7:0] tx_byte,  // Stream byte
  input  wire logic       tx_valid, // Byte valid
  input  wire logic       stall,    // Slow acceptance
  output logic            tx_ready  // Byte accepted
);
  logic [7:0] got[$];  // Bytes in arrival order
  logic [1:0] cnt_r;   // Stall pacing
  logic [1:0] pos_r;   // 0 tag, 1 length, 2 value
  logic [7:0] tag_r;   // Tag of the object in flight
  logic [7:0] left_r;  // Value bytes still to come
  logic [7:0] char_r;  // Last characteristics byte
  logic [7:0] class_r; // Last measurement class byte
  logic [7:0] cur_r;   // Last current byte
  // Clock stop levels the terminal may use
  wire stop_high_ok = char_r[0] || char_r[2];
  wire stop_low_ok  = char_r[0] || char_r[3];
  // Current usable only inside the legal range
  wire cur_ok = cur_r != 8'h00 && cur_r != 8'hFF && cur_r <= 8'h3C;
  // Current must be rescaled when measured at another class
  wire rescale = class_r != USE_CLASS;
  // Accept bytes; order kept, no merge, unknown tags kept for skipping
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r    <= 2'd0;
      tx_ready <= 1'b0;
      pos_r    <= 2'd0;
      tag_r    <= 8'h00;
      left_r   <= 8'h00;
      char_r   <= 8'h00;
      class_r  <= 8'h00;
      cur_r    <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 2'd1;
      tx_ready <= !stall || cnt_r == 2'd3;
      if (tx_valid && tx_ready) begin
        got.push_back(tx_byte);
        case (pos_r)
          2'd0: begin
            tag_r <= tx_byte;
            pos_r <= 2'd1;
          end
          2'd1: begin
            left_r <= tx_byte;
            pos_r  <= (tx_byte == 8'h00) ? 2'd0 : 2'd2;
          end
          default: begin
            // Value bytes counted off by length, known tag or not
            left_r <= left_r - 8'h01;
            if (left_r == 8'h01) pos_r <= 2'd0;
            if (tag_r == 8'h80) char_r <= tx_byte;
            if (tag_r == 8'h81 && left_r == 8'h03) class_r <= tx_byte;
            if (tag_r == 8'h81 && left_r == 8'h02) cur_r <= tx_byte;
          end
        endcase
      end
    end
  end
endmodule // cptlv_sink
`default_nettype wire

// ---- cptlv_top_bench.sv ----
// Bench of the object builder: AHB-Lite writes, stream compared.
// Assumes zero wait bus and the sink model beside the design.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module cptlv_top_bench;
  logic        hclk, hresetn, hsel, hwrite, stall; // Bench drives
  logic [31:0] haddr, hwdata, rd;                  // Bus values
  logic [1:0]  htrans;                             // Transfer type
  logic [2:0]  hsize;                              // Word size
  logic [31:0] hrdata;                             // Read data
  logic        hreadyout, hresp, tx_valid, tx_ready; // Design and sink outputs
  logic [7:0]  tx_byte;                            // Stream byte
  logic [7:0]  exp_q[$];                           // Expected stream
  logic [7:0]  vals[5] = '{8'hFF, 8'h04, 8'h08, 8'hF2, 8'h0D}; // Char
  logic [1:0]  stops[5] = '{2'b11, 2'b01, 2'b10, 2'b00, 2'b11}; // Low,high
  int          miscompares, cmp_count, cycles;     // Counters
  wire         hready = hreadyout;                 // One slave
  cptlv_top #(.MINCK_N(2)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .tx_byte(tx_byte), .tx_valid(tx_valid),
    .tx_ready(tx_ready));
  cptlv_sink u_sink (.hclk(hclk), .hresetn(hresetn), .tx_byte(tx_byte),
    .tx_valid(tx_valid), .stall(stall), .tx_ready(tx_ready));
  ////////////////////////////////////////
  // Clock and timeout
  initial begin hclk = 1'b0; forever #2.5 hclk = ~hclk; end
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 6000) begin miscompares++; finish_test(); end
  end
  // Counts, verdict and end of run
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One single AHB-Lite word transfer
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1; htrans <= 2'b10; hwrite <= w; haddr <= {24'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00; hsel <= 1'b0; hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
    `CHK(hresp, 1'b0)
  endtask
  // Start a frame and compare it with exp_q
  task automatic run(input logic [6:0] en);
    u_sink.got.delete();
    bus(1'b1, cptlv_pkg::OFS_CTRL, {1'b1, 24'h0, en}, rd);
    while (u_sink.got.size() < exp_q.size()) @(posedge hclk);
    repeat (6) @(posedge hclk);
    `CHK(u_sink.got.size(), exp_q.size())
    foreach (exp_q[i]) `CHK(u_sink.got[i], exp_q[i])
  endtask
  ////////////////////////////////////////
  initial begin
    hresetn = 1'b0; hsel = 1'b0; hwrite = 1'b0; htrans = 2'b00;
    haddr = 32'h0; hwdata = 32'h0; hsize = 3'b010; stall = 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, cptlv_pkg::OFS_POWER, 32'h0, rd);
    `CHK(rd, 32'h0000_01FF)
    bus(1'b0, cptlv_pkg::OFS_MINCK, 32'h0, rd);
    `CHK(rd, 32'h0000_FFFF)
    bus(1'b0, 8'h20, 32'h0, rd);
    `CHK(rd, 32'h0) // Unmapped reads zero
    $display("test reset values done");
    foreach (vals[i]) begin
      bus(1'b1, cptlv_pkg::OFS_CHAR, {24'h0, vals[i]}, rd);
      bus(1'b0, cptlv_pkg::OFS_CHAR, 32'h0, rd);
      `CHK(rd, {24'h0, vals[i] & 8'h7D})
      exp_q = '{8'h80, 8'h01, vals[i] & 8'h7D};
      run(7'h00);
      `CHK({u_sink.stop_low_ok, u_sink.stop_high_ok}, stops[i])
    end
    $display("test characteristics done");
    stall <= 1'b1;
    bus(1'b1, cptlv_pkg::OFS_POWER, 32'h0002_3F05, rd);
    bus(1'b1, cptlv_pkg::OFS_MINCK, 32'h0000_200A, rd);
    bus(1'b1, cptlv_pkg::OFS_SIZE, 32'h1234_0100, rd);
    bus(1'b1, cptlv_pkg::OFS_RSV, 32'h0, rd);
    bus(1'b1, cptlv_pkg::OFS_MISC, 32'h0000_01FF, rd);
    exp_q = '{8'h80, 8'h01, 8'h0D, 8'h81, 8'h03, 8'h02, 8'h3C, 8'hFF,
              8'h82, 8'h01, 8'h0A, 8'h82, 8'h01, 8'h20, 8'h83, 8'h02,
              8'h01, 8'h00, 8'h84, 8'h01, 8'h01, 8'h85, 8'h02, 8'h00,
              8'h00, 8'h86, 8'h02, 8'h01, 8'h00, 8'h87, 8'h01, 8'h01};
    run(7'h7F);
    `CHK({u_sink.cur_ok, u_sink.rescale}, 2'b11)
    $display("test full frame stalled done");
    stall <= 1'b0;
    bus(1'b1, cptlv_pkg::OFS_POWER, 32'h0001_000A, rd);
    exp_q = '{8'h80, 8'h01, 8'h0D, 8'h81, 8'h03, 8'h01, 8'h01, 8'h0A,
              8'h83, 8'h02, 8'h12, 8'h34};
    run(7'h05);
    `CHK({u_sink.cur_ok, u_sink.rescale}, 2'b10)
    bus(1'b0, cptlv_pkg::OFS_STAT, 32'h0, rd);
    `CHK(rd, 32'h0000_3400)
    $display("test unclamped sizes done");
    finish_test();
  end
endmodule // cptlv_top_bench
`default_nettype wire
